/* hw/vic_pkg.sv */
// Purpose: shared constants, types and register map of the vibration input conditioning block
// Assumes: 50 MHz CLOCK, two channels, 16-bit signed samples
// Notes: byte offsets on the register bus; channel 1 sits one channel stride above channel 0
`default_nettype none

package vic_pkg;
    // ************************************************************
    // sizes and clocking
    // ************************************************************
    localparam int NCH = 2;
    localparam int DW = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int CLK_PERIOD_NS = 20;
    localparam int HOLD_TIME_NS = 100000;
    localparam int HOLD_CYCLES = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_UOFS = 8'h04;
    localparam logic [7:0] REG_UGAIN = 8'h08;
    localparam logic [7:0] REG_VOFS = 8'h0c;
    localparam logic [7:0] REG_VGAIN = 8'h10;
    localparam logic [7:0] REG_STAT = 8'h14;
    localparam logic [7:0] REG_RATE = 8'h80;
    localparam int CH_SEL_BIT = 6;
    localparam logic [7:0] CH_OFS_MASK = 8'h3f;
    localparam logic [7:0] RATE_MASK = 8'hbf;
    localparam int CTRL_FILT_LSB = 0;
    localparam int CTRL_UEN_BIT = 4;
    localparam int CTRL_VEN_BIT = 5;
    localparam int CTRL_AOFS_BIT = 6;
    localparam int CTRL_LVL_LSB = 8;
    localparam int STAT_HOLD_BIT = 16;
    localparam int STAT_GAIN20_BIT = 17;

    // ************************************************************
    // arithmetic
    // ************************************************************
    localparam int GAIN_FRAC = 14;
    localparam int AVG_FRAC = 20;
    localparam int AVG_W = DW + AVG_FRAC;
    localparam logic [4:0] AVG_BASE_SHIFT = 5'h0c;
    localparam logic [15:0] GAIN_ONE = 16'h4000;
    localparam logic signed [33:0] SAT_MAX = 34'sh0_0000_7fff;
    localparam logic signed [33:0] SAT_MIN = -34'sh0_0000_8000;

    typedef enum logic [2:0] {
        FC_10HZ, FC_100HZ, FC_500HZ, FC_1KHZ, FC_5KHZ, FC_10KHZ, FC_25KHZ, FC_2KHZ
    } filt_code_t;

    typedef struct packed {
        filt_code_t filt;
        logic user_en;
        logic vend_en;
        logic aofs_en;
        logic [2:0] lvl;
        logic [15:0] uofs;
        logic [15:0] ugain;
        logic [15:0] vofs;
        logic [15:0] vgain;
    } chan_cfg_t;

    localparam chan_cfg_t CFG_RESET = '{FC_10KHZ, 1'b0, 1'b1, 1'b0, 3'h0, 16'h0000, GAIN_ONE, 16'h0000, GAIN_ONE};

    typedef struct packed {
        filt_code_t filt;
        logic gain20;
        logic [1:0] aa_pre;
        logic [1:0] aa_post;
    } analog_ctrl_t;

    typedef struct packed {
        logic ch;
        logic cycle_start;
        logic [15:0] value;
    } out_word_t;

    localparam int OUT_W = $bits(out_word_t);
endpackage : vic_pkg

`default_nettype wire

/* hw/vibration_input_conditioning.sv */
// Purpose: per-channel filter selection, calibration and active offset adjustment, sync-paced delivery
// Assumes: converter samples arrive on CLOCK; sync events arrive as pins; master drives Avalon-MM
// Notes: corrected samples leave through an 8-word FIFO with valid/ready
//
// Notes on behaviour
// - each channel has a selectable hardware fifth-order Butterworth low-pass stage.
// - anti-aliasing stages follow the selected cutoff automatically.
// - cutoff codes 0..7 map to 10,100,500,1k,5k,10k,25k,2k Hz.
// - the 10 Hz code switches on an extra gain of twenty.
// - no bypass; every code selects a cutoff.
// - filter setting is held and written per channel.
// - a filter change briefly suspends delivery of new samples.
// - with offset adjustment on, a long-term sample average runs continuously.
// - the average replaces the vendor offset; the user offset becomes zero, or the average when the vendor stage is off; gains stay as set.
// - averaging weight level 0..7 is 1/4096 halving down to 1/524288.
// - offset adjustment has its own enable per channel.
// - user stage subtracts user offset then scales by user gain, else passes.
`default_nettype none

// ************************************************************
// sample fifo
// ************************************************************
module sample_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side, registered head
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic out_valid_reg;
    logic [WIDTH-1:0] out_data_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg < (AW + 1)'(DEPTH));
    assign push = in_valid && in_ready;
    assign pop = (count_reg != '0) && (!out_valid_reg || out_ready);
    assign out_valid = out_valid_reg;
    assign out_data = out_data_reg;

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= AW'((wr_ptr_reg + 1'b1) % DEPTH);
            end
            if (pop) begin
                rd_ptr_reg <= AW'((rd_ptr_reg + 1'b1) % DEPTH);
            end
            count_reg <= count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end else if (pop) begin
            out_valid_reg <= 1'b1;
            out_data_reg <= mem[rd_ptr_reg];
        end else if (out_ready) begin
            out_valid_reg <= 1'b0;
        end
    end
endmodule : sample_fifo

// ************************************************************
// conditioning top
// ************************************************************
module vibration_input_conditioning #(
    parameter int HOLDOFF_CYCLES = vic_pkg::HOLD_CYCLES
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESET,
    // avalon-mm slave
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // sync event pins
    input wire logic SYNC0,
    input wire logic SYNC1,
    // converter samples, same clock
    input wire logic [vic_pkg::NCH-1:0] ADC_VALID,
    input wire logic [vic_pkg::NCH-1:0][15:0] ADC_DATA,
    // analog filter control
    output vic_pkg::analog_ctrl_t [vic_pkg::NCH-1:0] ANALOG_CTRL,
    // corrected sample stream
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output vic_pkg::out_word_t OUT_DATA
);
    import vic_pkg::*;

    typedef enum {ST_IDLE, ST_CH0, ST_CH1} deliver_state_t;

    chan_cfg_t cfg_reg [NCH];
    analog_ctrl_t [NCH-1:0] analog_reg;
    logic [12:0] hold_reg [NCH];
    logic signed [AVG_W-1:0] acc_reg [NCH];
    logic [15:0] x_reg [NCH];
    logic [NCH-1:0] have_reg;
    logic [2:0] s0_sync_reg;
    logic [2:0] s1_sync_reg;
    logic cycle_flag_reg;
    logic [15:0] rate_cnt_reg;
    logic [15:0] rate_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    deliver_state_t state_reg;
    logic sync0_evt;
    logic sync1_evt;
    logic cur_ch;
    logic deliverable;
    logic fifo_ready;
    logic push;
    logic wr_go;
    logic [31:0] rd_mux;
    logic [15:0] cond_val;
    out_word_t push_word;

    function automatic logic [15:0] sat16(input logic signed [33:0] v);
        if (v > SAT_MAX) begin
            return 16'h7fff;
        end else if (v < SAT_MIN) begin
            return 16'h8000;
        end
        return v[15:0];
    endfunction : sat16

    // subtract an offset, then scale by an unsigned fixed-point gain
    function automatic logic [15:0] cal_step(input logic [15:0] x, input logic [15:0] off, input logic [15:0] gain);
        logic signed [16:0] d;
        logic signed [33:0] p;
        d = $signed({x[15], x}) - $signed({off[15], off});
        p = d * $signed({1'b0, gain});
        return sat16(p >>> GAIN_FRAC);
    endfunction : cal_step

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : be_merge

    function automatic logic [1:0] aa_band(input filt_code_t f);
        unique case (f)
            FC_10HZ, FC_100HZ: return 2'h0;
            FC_500HZ, FC_1KHZ, FC_2KHZ: return 2'h1;
            FC_5KHZ, FC_10KHZ: return 2'h2;
            FC_25KHZ: return 2'h3;
        endcase
    endfunction : aa_band

    function automatic logic [15:0] avg_of(input logic signed [AVG_W-1:0] acc);
        return acc[AVG_FRAC +: DW];
    endfunction : avg_of

    function automatic logic [31:0] ctrl_word(input chan_cfg_t c);
        logic [31:0] w;
        w = '0;
        w[CTRL_FILT_LSB +: 3] = c.filt;
        w[CTRL_UEN_BIT] = c.user_en;
        w[CTRL_VEN_BIT] = c.vend_en;
        w[CTRL_AOFS_BIT] = c.aofs_en;
        w[CTRL_LVL_LSB +: 3] = c.lvl;
        return w;
    endfunction : ctrl_word

    // ************************************************************
    // sync event pins
    // ************************************************************
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            s0_sync_reg <= '0;
            s1_sync_reg <= '0;
        end else begin
            s0_sync_reg <= {s0_sync_reg[1:0], SYNC0};
            s1_sync_reg <= {s1_sync_reg[1:0], SYNC1};
        end
    end

    // edges are taken between the second and third stage only
    assign sync0_evt = s0_sync_reg[1] && !s0_sync_reg[2];
    assign sync1_evt = s1_sync_reg[1] && !s1_sync_reg[2];

    // ************************************************************
    // register bus
    // ************************************************************
    assign wr_go = AVS_WRITE && !wait_reg;

    always_comb begin
        logic ch;
        chan_cfg_t c;
        ch = AVS_ADDRESS[CH_SEL_BIT];
        c = cfg_reg[ch];
        rd_mux = '0;
        if ((AVS_ADDRESS & RATE_MASK) == REG_RATE) begin
            rd_mux = {16'h0000, rate_reg};
        end else if (!AVS_ADDRESS[7]) begin
            unique case (AVS_ADDRESS & CH_OFS_MASK)
                REG_CTRL: rd_mux = ctrl_word(c);
                REG_UOFS: rd_mux = {16'h0000, c.uofs};
                REG_UGAIN: rd_mux = {16'h0000, c.ugain};
                REG_VOFS: rd_mux = {16'h0000, c.vofs};
                REG_VGAIN: rd_mux = {16'h0000, c.vgain};
                REG_STAT: begin
                    rd_mux = {16'h0000, avg_of(acc_reg[ch])};
                    rd_mux[STAT_HOLD_BIT] = (hold_reg[ch] != '0);
                    rd_mux[STAT_GAIN20_BIT] = analog_reg[ch].gain20;
                end
                default: rd_mux = '0;
            endcase
        end
    end

    // one wait state: the answer is ready at the second edge of every request
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            wait_reg <= 1'b1;
            rdata_reg <= '0;
        end else if ((AVS_READ || AVS_WRITE) && wait_reg) begin
            wait_reg <= 1'b0;
            rdata_reg <= rd_mux;
        end else begin
            wait_reg <= 1'b1;
        end
    end

    assign AVS_WAITREQUEST = wait_reg;
    assign AVS_READDATA = rdata_reg;

    // ************************************************************
    // per-channel configuration
    // ************************************************************
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            for (int i = 0; i < NCH; i++) begin
                cfg_reg[i] <= CFG_RESET;
            end
        end else if (wr_go && !AVS_ADDRESS[7]) begin
            for (int i = 0; i < NCH; i++) begin
                if (AVS_ADDRESS[CH_SEL_BIT] == 1'(i)) begin
                    logic [31:0] m;
                    m = be_merge(rd_mux, AVS_WRITEDATA, AVS_BYTEENABLE);
                    unique case (AVS_ADDRESS & CH_OFS_MASK)
                        REG_CTRL: begin
                            cfg_reg[i].filt <= filt_code_t'(m[CTRL_FILT_LSB +: 3]);
                            cfg_reg[i].user_en <= m[CTRL_UEN_BIT];
                            cfg_reg[i].vend_en <= m[CTRL_VEN_BIT];
                            cfg_reg[i].aofs_en <= m[CTRL_AOFS_BIT];
                            cfg_reg[i].lvl <= m[CTRL_LVL_LSB +: 3];
                        end
                        REG_UOFS: cfg_reg[i].uofs <= m[15:0];
                        REG_UGAIN: cfg_reg[i].ugain <= m[15:0];
                        REG_VOFS: cfg_reg[i].vofs <= m[15:0];
                        REG_VGAIN: cfg_reg[i].vgain <= m[15:0];
                        default: ;
                    endcase
                end
            end
        end
    end

    // ************************************************************
    // analog filter control and change holdoff
    // ************************************************************
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            for (int i = 0; i < NCH; i++) begin
                analog_reg[i] <= '{FC_10KHZ, 1'b0, aa_band(FC_10KHZ), aa_band(FC_10KHZ)};
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                analog_reg[i].filt <= cfg_reg[i].filt;
                analog_reg[i].gain20 <= (cfg_reg[i].filt == FC_10HZ);
                analog_reg[i].aa_pre <= aa_band(cfg_reg[i].filt);
                analog_reg[i].aa_post <= aa_band(cfg_reg[i].filt);
            end
        end
    end

    assign ANALOG_CTRL = analog_reg;

    // a changed code restarts the holdoff; samples converted meanwhile are dropped
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            for (int i = 0; i < NCH; i++) begin
                hold_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (analog_reg[i].filt != cfg_reg[i].filt) begin
                    hold_reg[i] <= 13'(HOLDOFF_CYCLES);
                end else if (hold_reg[i] != '0) begin
                    hold_reg[i] <= hold_reg[i] - 13'h0001;
                end
            end
        end
    end

    // ************************************************************
    // sample capture
    // ************************************************************
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            have_reg <= '0;
            for (int i = 0; i < NCH; i++) begin
                x_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (hold_reg[i] != '0) begin
                    have_reg[i] <= 1'b0;
                end else if (ADC_VALID[i]) begin
                    x_reg[i] <= ADC_DATA[i];
                    have_reg[i] <= 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // correction path
    // ************************************************************
    assign cur_ch = (state_reg == ST_CH1);

    always_comb begin
        chan_cfg_t c;
        logic [15:0] avg;
        logic [15:0] yh;
        logic [15:0] voff;
        logic [15:0] uoff;
        c = cfg_reg[cur_ch];
        avg = avg_of(acc_reg[cur_ch]);
        voff = c.aofs_en ? avg : c.vofs;
        uoff = c.aofs_en ? (c.vend_en ? 16'h0000 : avg) : c.uofs;
        yh = c.vend_en ? cal_step(x_reg[cur_ch], voff, c.vgain) : x_reg[cur_ch];
        cond_val = c.user_en ? cal_step(yh, uoff, c.ugain) : yh;
    end

    assign deliverable = have_reg[cur_ch] && (hold_reg[cur_ch] == '0);
    assign push = (state_reg != ST_IDLE) && deliverable && fifo_ready;
    assign push_word = '{cur_ch, cycle_flag_reg, cond_val};

    // long-term average: acc += (x - acc) * 2^-(12 + level)
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            for (int i = 0; i < NCH; i++) begin
                acc_reg[i] <= '0;
            end
        end else if (push && cfg_reg[cur_ch].aofs_en) begin
            logic signed [AVG_W:0] diff;
            diff = (AVG_W + 1)'($signed({x_reg[cur_ch], {AVG_FRAC{1'b0}}})) - (AVG_W + 1)'(acc_reg[cur_ch]);
            acc_reg[cur_ch] <= acc_reg[cur_ch] + AVG_W'(diff >>> (AVG_BASE_SHIFT + 5'(cfg_reg[cur_ch].lvl)));
        end
    end

    // ************************************************************
    // sync-paced delivery
    // ************************************************************
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: if (sync0_evt) state_reg <= ST_CH0;
                ST_CH0: if (push || !deliverable) state_reg <= ST_CH1;
                ST_CH1: if (push || !deliverable) state_reg <= ST_IDLE;
            endcase
        end
    end

    // the cycle mark sits on the first word after a second-sync edge; a new edge wins over the clear
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            cycle_flag_reg <= 1'b0;
        end else if (sync1_evt) begin
            cycle_flag_reg <= 1'b1;
        end else if (push) begin
            cycle_flag_reg <= 1'b0;
        end
    end

    // first-sync events counted per full cycle give the oversampling factor seen
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            rate_cnt_reg <= '0;
            rate_reg <= '0;
        end else if (sync1_evt) begin
            rate_reg <= rate_cnt_reg;
            rate_cnt_reg <= 16'(sync0_evt);
        end else if (sync0_evt) begin
            rate_cnt_reg <= rate_cnt_reg + 16'h0001;
        end
    end

    sample_fifo #(
        .WIDTH(OUT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(CLOCK),
        .reset(RESET),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data(push_word),
        .out_valid(OUT_VALID),
        .out_ready(OUT_READY),
        .out_data(OUT_DATA)
    );
endmodule : vibration_input_conditioning

`default_nettype wire

/* tb/vic_props.sv */
// Purpose: port-level checks of the conditioning block
// Assumes: one CLOCK domain, RESET synchronous active high
// Notes: bound into the top module
`default_nettype none

// ****
// checker
// ****
module vic_props #(
    parameter int HOLDOFF_CYCLES = vic_pkg::HOLD_CYCLES
) (
    // clock and bus
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    // analog control and stream
    input wire vic_pkg::analog_ctrl_t [vic_pkg::NCH-1:0] ANALOG_CTRL,
    input wire logic OUT_VALID,
    input wire logic OUT_READY,
    input wire vic_pkg::out_word_t OUT_DATA
);
    import vic_pkg::*;
    default clocking cb @(posedge CLOCK); endclocking
    logic wr0;
    assign wr0 = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == REG_CTRL && AVS_BYTEENABLE[0];
    function automatic logic [1:0] band(input logic [2:0] f);
        case (f)
            3'h0, 3'h1: return 2'h0;
            3'h4, 3'h5: return 2'h2;
            3'h6: return 2'h3;
            default: return 2'h1;
        endcase
    endfunction : band
    property p_wait_one; disable iff (RESET) !AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait low too long");
    property p_answer; disable iff (RESET) (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
    a_answer: assert property (p_answer) else $error("request not answered");
    property p_gain0; disable iff (RESET) ANALOG_CTRL[0].gain20 == (ANALOG_CTRL[0].filt == FC_10HZ); endproperty
    a_gain0: assert property (p_gain0) else $error("gain ch0 wrong");
    property p_gain1; disable iff (RESET) ANALOG_CTRL[1].gain20 == (ANALOG_CTRL[1].filt == FC_10HZ); endproperty
    a_gain1: assert property (p_gain1) else $error("gain ch1 wrong");
    property p_band; disable iff (RESET) ANALOG_CTRL[0].aa_pre == band(ANALOG_CTRL[0].filt)
        && ANALOG_CTRL[0].aa_post == band(ANALOG_CTRL[0].filt) && ANALOG_CTRL[1].aa_pre == band(ANALOG_CTRL[1].filt);
    endproperty
    a_band: assert property (p_band) else $error("anti-alias band wrong");
    property p_follow; disable iff (RESET) wr0 |-> ##2 ANALOG_CTRL[0].filt == $past(AVS_WRITEDATA[2:0], 2); endproperty
    a_follow: assert property (p_follow) else $error("cutoff not applied");
    property p_ch1_hold; disable iff (RESET) wr0 |=> ##1 $stable(ANALOG_CTRL[1].filt); endproperty
    a_ch1_hold: assert property (p_ch1_hold) else $error("ch1 cutoff disturbed");
    property p_out_hold; disable iff (RESET) OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA); endproperty
    a_out_hold: assert property (p_out_hold) else $error("stream word dropped");
    property p_unmapped; disable iff (RESET) AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h28 |->
        AVS_READDATA == 0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_reset; disable iff (RESET) $fell(RESET) |-> AVS_WAITREQUEST && !OUT_VALID
        && ANALOG_CTRL[0].filt == FC_10KHZ; endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule : vic_props

bind vibration_input_conditioning vic_props #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES)) props (.CLOCK, .RESET,
    .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
    .ANALOG_CTRL, .OUT_VALID, .OUT_READY, .OUT_DATA);

`default_nettype wire

/* tb/sync_master_model.sv */
// Purpose: bus master side making the sync events
// Assumes: events derive from the shared CLOCK
// Notes: idle pins stay low between cycles
`default_nettype none

// ****
// sync source
// ****
module sync_master_model (
    // clock and sync pins
    input wire logic CLOCK,
    output var logic SYNC0,
    output var logic SYNC1
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        SYNC0 = 1'b0;
        SYNC1 = 1'b0;
    end
    // one bus cycle: second sync opens it, n first syncs p clocks apart; same timebase as the block
    task automatic run_cycle(input int n, input int p);
        @(posedge CLOCK);
        SYNC1 <= 1'b1;
        repeat (2) @(posedge CLOCK);
        SYNC1 <= 1'b0;
        repeat (n) begin
            SYNC0 <= 1'b1;
            repeat (2) @(posedge CLOCK);
            SYNC0 <= 1'b0;
            repeat (p - 2) @(posedge CLOCK);
        end
    endtask : run_cycle
endmodule : sync_master_model

`default_nettype wire

/* tb/test_vibration_input_conditioning.sv */
// Purpose: self-checking bench of the conditioning block
// Assumes: short holdoff parameter, identity vendor stage
// Notes: one task per scenario
`default_nettype none

// ****
// bench
// ****
module test_vibration_input_conditioning;
    timeunit 1ns;
    timeprecision 1ns;
    import vic_pkg::*;
    localparam int HOLD = 20;
    logic CLOCK, RESET, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, SYNC0, SYNC1, OUT_VALID, OUT_READY;
    logic [7:0] AVS_ADDRESS;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd;
    logic [3:0] AVS_BYTEENABLE;
    logic [NCH-1:0] ADC_VALID;
    logic [NCH-1:0][15:0] ADC_DATA;
    analog_ctrl_t [NCH-1:0] ANALOG_CTRL;
    out_word_t OUT_DATA;
    int n_fail = 0, cmp_count = 0, cycles = 0;
    vibration_input_conditioning #(.HOLDOFF_CYCLES(HOLD)) dut (.CLOCK, .RESET, .AVS_ADDRESS, .AVS_READ,
        .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .SYNC0, .SYNC1,
        .ADC_VALID, .ADC_DATA, .ANALOG_CTRL, .OUT_VALID, .OUT_READY, .OUT_DATA);
    sync_master_model master (.CLOCK, .SYNC0, .SYNC1);
    initial begin
        CLOCK = 1'b0;
        forever #10 CLOCK = ~CLOCK;
    end
    // a hang is cut off far above the length of the run
    always @(posedge CLOCK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge CLOCK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0);
        chk("answer", 2, n);
        rd = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask : bus
    task automatic s_reset();
        bus(0, REG_CTRL, 0); chk("ctrl0", 32'h25, rd);
        bus(0, REG_UGAIN | 8'h40, 0); chk("ugain1", 32'h4000, rd);
        chk("analog0", {24'h0, FC_10KHZ, 1'b0, 4'ha}, {24'h0, ANALOG_CTRL[0]});
        bus(1, 8'h28, 32'h1234);
        bus(0, 8'h28, 0); chk("unmapped", 0, rd);
    endtask : s_reset
    task automatic s_filter();
        for (int c = 0; c < 8; c++) begin
            bus(1, REG_CTRL, 32'h20 | 32'(c));
            repeat (3) @(posedge CLOCK);
            chk("filt0", 32'(c), 32'(ANALOG_CTRL[0].filt));
            chk("gain20", 32'(c == 0), 32'(ANALOG_CTRL[0].gain20));
            chk("filt1", 32'(FC_10KHZ), 32'(ANALOG_CTRL[1].filt));
            bus(0, REG_STAT, 0); chk("busy", 1, 32'(rd[STAT_HOLD_BIT]));
            repeat (HOLD + 2) @(posedge CLOCK);
            bus(0, REG_STAT, 0); chk("idle", 0, 32'(rd[STAT_HOLD_BIT]));
        end
    endtask : s_filter
    task automatic s_stream();
        int n;
        ADC_DATA <= {16'h0200, 16'h0100};
        ADC_VALID <= 2'b11;
        bus(1, REG_UOFS, 32'h10);
        bus(1, REG_UGAIN, 32'h8000);
        bus(1, REG_CTRL, 32'h35);
        repeat (HOLD + 4) @(posedge CLOCK);
        OUT_READY <= 1'b0;
        master.run_cycle(6, 10);
        repeat (10) @(posedge CLOCK);
        n = 0;
        OUT_READY <= 1'b1;
        repeat (40) begin
            @(posedge CLOCK);
            if (OUT_VALID === 1'b1) begin
                chk("ch", 32'(n % 2), 32'(OUT_DATA.ch));
                chk("value", (n % 2) ? 32'h200 : 32'h1e0, 32'(OUT_DATA.value));
                if (n == 0) chk("start", 1, 32'(OUT_DATA.cycle_start));
                n++;
            end
        end
        chk("filled", 10, n);
    endtask : s_stream
    task automatic s_aofs();
        ADC_DATA <= {16'h4000, 16'h4000};
        bus(1, REG_CTRL, 32'h165);
        bus(1, REG_CTRL | 8'h40, 32'h65);
        repeat (HOLD + 4) @(posedge CLOCK);
        master.run_cycle(1, 10);
        repeat (10) @(posedge CLOCK);
        bus(0, REG_STAT, 0); chk("avg0", 32'h2, {16'h0, rd[15:0]});
        bus(0, REG_STAT | 8'h40, 0); chk("avg1", 32'h4, {16'h0, rd[15:0]});
    endtask : s_aofs
    initial begin
        RESET = 1'b1;
        {AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA, ADC_VALID, ADC_DATA} = '0;
        AVS_BYTEENABLE = 4'hf;
        OUT_READY = 1'b1;
        repeat (3) @(posedge CLOCK);
        RESET <= 1'b0;
        s_reset();
        s_filter();
        s_stream();
        s_aofs();
        master.run_cycle(4, 10);
        master.run_cycle(4, 10);
        repeat (10) @(posedge CLOCK);
        bus(0, REG_RATE, 0); chk("rate", 4, rd);
        give_verdict();
    end
endmodule : test_vibration_input_conditioning

`default_nettype wire
